// ---- hdl/acs_regs.vh ----
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
// wake-up time after the rising edge of convert start, ns
`define ACS_WAKE_NS        1000
`define ACS_CLK_NS         10
// cycles of wake-up, rounded up
`define ACS_WAKE_CYC       ((`ACS_WAKE_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
// slave addresses, 7 bit
`define ACS_ADDR_FLOAT     7'h20
`define ACS_ADDR_V0_GND    7'h21
`define ACS_ADDR_V0_VDD    7'h22
`define ACS_ADDR_V1_GND    7'h23
`define ACS_ADDR_V1_VDD    7'h24
// encoding of the sensed address-select level
`define ACS_SEL_GND        2'h0
`define ACS_SEL_VDD        2'h1
`define ACS_SEL_FLOAT      2'h2
// output pin function
`define ACS_FUNC_ALERT     1'b0
`define ACS_FUNC_BUSY      1'b1
`endif

// ---- hdl/acs_convert_ctrl.v ----
`timescale 1ns/1ps
`include "acs_regs.vh"
// Contract
// R1 - only a rising convert start edge wakes the converter; wake-up lasts 1 us
// R2 - falling convert start edge puts track/hold in hold and starts conversion
// R3 - driver holds convert start high at least 1 us before falling
// R4 - one output pin works as alert or busy, chosen by configuration
// R5 - alert mode, when enabled: assert if result above upper or below lower limit
// R6 - busy mode: output asserted exactly while a conversion runs
// R7 - version 0: address 0100001 on ground, 0100010 on supply
// R8 - version 1: address 0100011 on ground, 0100100 on supply
// R9 - floating address select gives address 0100000 on any version
// R10 - data line is open drain; nobody drives it high
// R11 - clock line is only an input from the bus master
// R12 - after power-up the converter sits in power-down until requested
// R13 - converter shuts down after each conversion; bus stays serviceable
// R14 - limit compare and busy release happen when the result is latched
module acs_convert_ctrl #(
  parameter DATA_W  = 12,
  parameter WAKE_CYC = `ACS_WAKE_CYC
) (
  input  wire              core_clk,
  input  wire              srst,
  input  wire              convert_start_n,
  input  wire [1:0]        slave_address_pin,
  input  wire              hw_version,
  input  wire              pin_function,
  input  wire              alert_enable,
  input  wire [DATA_W-1:0] upper_limit,
  input  wire [DATA_W-1:0] lower_limit,
  input  wire              conv_done,
  input  wire [DATA_W-1:0] conv_result,
  input  wire              scl_in,
  input  wire              sda_in,
  input  wire              sda_pull_low,
  output reg               alert_busy_out,
  output reg               converter_awake,
  output reg               track_hold,
  output reg               conv_start,
  output reg               conv_invalid,
  output reg  [DATA_W-1:0] result_out,
  output reg  [6:0]        slave_address,
  output reg               scl_sync,
  output reg               sda_sync,
  output reg               sda_out,
  output reg               sda_oe
);

  localparam ST_DOWN = 2'h0;
  localparam ST_WAKE = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam CNT_W   = 16;
  localparam NPIN    = 6;

  // bit positions in the synchroniser bank
  localparam P_CS    = 0;
  localparam P_SCL   = 1;
  localparam P_SDA   = 2;
  localparam P_SEL   = 3;
  localparam P_VER   = 5;

  // reset levels match idle pins, so no false edge follows reset
  localparam [NPIN-1:0] PIN_RST = {1'b0, `ACS_SEL_FLOAT, 1'b1, 1'b1, 1'b0};

  wire [NPIN-1:0] pin_raw;
  wire [NPIN-1:0] pin_s;
  reg             cs_q;
  reg [1:0]       state_q;
  reg [1:0]       state_d;
  reg [CNT_W-1:0] wake_cnt_q;
  reg             wake_ok_q;
  reg             alert_q;
  wire            cs_rise;
  wire            cs_fall;
  wire            wake_hit;
  wire            fall_take;
  wire            done_take;
  wire            out_of_range;

  // address chosen from version and sensed select level
  function [6:0] pick_addr;
    input [1:0] sel;
    input       ver;
    begin
      case (sel)
        `ACS_SEL_GND: pick_addr = ver ? `ACS_ADDR_V1_GND : `ACS_ADDR_V0_GND; // R7 R8
        `ACS_SEL_VDD: pick_addr = ver ? `ACS_ADDR_V1_VDD : `ACS_ADDR_V0_VDD; // R7 R8
        default:      pick_addr = `ACS_ADDR_FLOAT; // R9
      endcase
    end
  endfunction

  // all pins and the version strap gathered into one bank
  assign pin_raw = {hw_version, slave_address_pin, sda_in, scl_in, convert_start_n};

  // two-stage synchronisers; only the second stage is read
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_sync
      reg meta_q;
      reg sync_q;
      always @(posedge core_clk) begin
        if (srst) begin
          meta_q <= PIN_RST[g];
          sync_q <= PIN_RST[g];
        end else begin
          meta_q <= pin_raw[g];
          sync_q <= meta_q;
        end
      end
      assign pin_s[g] = sync_q;
    end
  endgenerate

  // last synchronised convert start level, for edge finding
  always @(posedge core_clk) begin
    if (srst)
      cs_q <= PIN_RST[P_CS];
    else
      cs_q <= pin_s[P_CS];
  end

  assign cs_rise   = pin_s[P_CS] & ~cs_q;
  assign cs_fall   = ~pin_s[P_CS] & cs_q;
  // a fall only counts once a wake edge has been seen
  assign fall_take = (state_q == ST_WAKE) & cs_fall; // R2
  // results arriving outside a conversion are dropped
  assign done_take = (state_q == ST_CONV) & conv_done; // R14
  // last wake cycle already counts, so an exact 1 us high time is valid
  assign wake_hit  = (wake_cnt_q == WAKE_CYC[CNT_W-1:0] - 1'b1); // R3
  // strict compare on both limits
  assign out_of_range = (conv_result > upper_limit) || (conv_result < lower_limit); // R5

  // converter power sequencing
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_DOWN: if (cs_rise) state_d = ST_WAKE; // R1
      ST_WAKE: if (cs_fall) state_d = ST_CONV; // R2
      ST_CONV: if (conv_done) state_d = ST_DOWN; // R13 R14
      default: state_d = ST_DOWN;
    endcase
  end

  // power state; a fall while still asleep is ignored
  always @(posedge core_clk) begin
    if (srst)
      state_q <= ST_DOWN; // R12
    else
      state_q <= state_d;
  end

  // wake-up timer, restarted by every rise, stops once long enough
  always @(posedge core_clk) begin
    if (srst) begin
      wake_cnt_q <= {CNT_W{1'b0}};
      wake_ok_q  <= 1'b0;
    end else if (cs_rise) begin
      wake_cnt_q <= {CNT_W{1'b0}};
      wake_ok_q  <= 1'b0;
    end else if (state_q == ST_WAKE && !wake_ok_q) begin
      wake_cnt_q <= wake_cnt_q + 1'b1;
      if (wake_hit)
        wake_ok_q <= 1'b1; // R1
    end
  end

  // power and hold flags follow the next state, in step with the strobe
  always @(posedge core_clk) begin
    if (srst) begin
      converter_awake <= 1'b0;
      track_hold      <= 1'b0;
    end else begin
      converter_awake <= (state_d != ST_DOWN); // R1 R13
      track_hold      <= (state_d == ST_CONV); // R2
    end
  end

  // start strobe and short-pulse flag; a short pulse still converts
  always @(posedge core_clk) begin
    if (srst) begin
      conv_start   <= 1'b0;
      conv_invalid <= 1'b0;
    end else begin
      conv_start <= fall_take; // R2
      if (fall_take)
        conv_invalid <= ~(wake_ok_q | wake_hit); // R3
    end
  end

  // result and limit check latched together, so the alert is never stale
  always @(posedge core_clk) begin
    if (srst) begin
      result_out <= {DATA_W{1'b0}};
      alert_q    <= 1'b0;
    end else if (done_take) begin
      result_out <= conv_result;
      alert_q    <= out_of_range; // R5 R14
    end
  end

  // shared pin; busy follows the conversion, alert the last result
  always @(posedge core_clk) begin
    if (srst)
      alert_busy_out <= 1'b0;
    else if (pin_function == `ACS_FUNC_BUSY)
      alert_busy_out <= (state_d == ST_CONV); // R4 R6
    else
      alert_busy_out <= alert_enable & alert_q; // R4 R5
  end

  // bus address from the synchronised version and select level
  always @(posedge core_clk) begin
    if (srst)
      slave_address <= `ACS_ADDR_FLOAT;
    else
      slave_address <= pick_addr(pin_s[P_SEL+1:P_SEL], pin_s[P_VER]); // R7 R8 R9
  end

  // serial pins; data output only ever pulls low, never drives high
  always @(posedge core_clk) begin
    if (srst) begin
      scl_sync <= 1'b1;
      sda_sync <= 1'b1;
      sda_out  <= 1'b0;
      sda_oe   <= 1'b0;
    end else begin
      scl_sync <= pin_s[P_SCL]; // R11
      sda_sync <= pin_s[P_SDA];
      sda_out  <= 1'b0; // R10
      sda_oe   <= sda_pull_low; // R10
    end
  end

endmodule

// ---- verification/acs_cs_host.sv ----
`timescale 1ns/1ps
module acs_cs_host (
  input  logic core_clk,
  output logic convert_start_n
);
  // idle low, so a fall in power-down never occurs by accident
  initial convert_start_n = 1'b0;
  // one start request: rise, hold high for hi cycles, fall
  task pulse(input int hi);
    @(posedge core_clk) convert_start_n <= 1'b1;
    repeat (hi) @(posedge core_clk);
    convert_start_n <= 1'b0;
  endtask
endmodule

// ---- verification/acs_convert_ctrl_chk.sv ----
`timescale 1ns/1ps
module acs_chk (
  input logic       core_clk,
  input logic       srst,
  input logic       convert_start_n,
  input logic [1:0] slave_address_pin,
  input logic       pin_function,
  input logic       conv_done,
  input logic       sda_pull_low,
  input logic       alert_busy_out,
  input logic       converter_awake,
  input logic       track_hold,
  input logic       conv_start,
  input logic [6:0] slave_address,
  input logic       sda_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // strobe lands in hold and lasts one cycle
  sequence start_s; track_hold ##1 !conv_start; endsequence
  start_pulse_a: assert property (conv_start |-> start_s)
    else $error("start strobe bad");
  hold_wake_a: assert property ($rose(track_hold) |-> $past(converter_awake))
    else $error("hold without wake");
  wake_rise_a: assert property ($rose(converter_awake) |-> $past(convert_start_n, 3))
    else $error("wake without rise");
  conv_end_a: assert property (track_hold && conv_done |=> !track_hold && !converter_awake)
    else $error("no shutdown");
  hold_busy_a: assert property (track_hold && !conv_done |=> track_hold)
    else $error("hold dropped");
  busy_out_a: assert property (pin_function && $past(pin_function) |-> alert_busy_out == track_hold)
    else $error("busy mismatch");
  sda_follow_a: assert property (sda_oe == $past(sda_pull_low))
    else $error("data enable lag");
  addr_float_a: assert property (slave_address_pin[1] [*6] |-> slave_address == 7'h20)
    else $error("float address");
endmodule
bind acs_convert_ctrl acs_chk u_chk (.core_clk, .srst, .convert_start_n, .slave_address_pin,
  .pin_function, .conv_done, .sda_pull_low, .alert_busy_out, .converter_awake, .track_hold,
  .conv_start, .slave_address, .sda_oe);

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic        core_clk = 0, srst = 1, hw_version = 0, pin_function = 0, alert_enable = 1;
  logic        conv_done = 0, scl_in = 1, sda_pull_low = 0, convert_start_n, alert_busy_out;
  logic        converter_awake, track_hold, conv_start, conv_invalid, scl_sync, sda_sync;
  logic        sda_out, sda_oe;
  logic [1:0]  slave_address_pin = 2'h0;
  logic [6:0]  slave_address;
  logic [11:0] upper_limit = 12'h800, lower_limit = 12'h100, conv_result = 12'h000, result_out;
  int          fail_count = 0, n_tests = 0;
  wire         sda_in = sda_oe ? sda_out : 1'b1; // pull-up wins when released
  acs_cs_host host (.core_clk, .convert_start_n);
  // short wake count keeps the run brief
  acs_convert_ctrl #(.WAKE_CYC(4)) DUT (.core_clk, .srst, .convert_start_n, .slave_address_pin,
    .hw_version, .pin_function, .alert_enable, .upper_limit, .lower_limit, .conv_done,
    .conv_result, .scl_in, .sda_in, .sda_pull_low, .alert_busy_out, .converter_awake,
    .track_hold, .conv_start, .conv_invalid, .result_out, .slave_address, .scl_sync,
    .sda_sync, .sda_out, .sda_oe);
  initial forever #5 core_clk = ~core_clk;
  task chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("mismatches=%0d checks=%0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // power-down refuses a stray result
  task t_idle;
    @(posedge core_clk);
    conv_result <= 12'hABC;
    conv_done   <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk({converter_awake, track_hold, conv_start, result_out}, 15'h0000);
  endtask
  // version and select pin, all eight codes
  task t_addr;
    logic [6:0] e[8] = '{7'h21, 7'h22, 7'h20, 7'h20, 7'h23, 7'h24, 7'h20, 7'h20};
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      {hw_version, slave_address_pin} <= i[2:0];
      repeat (5) @(posedge core_clk);
      #1 chk(slave_address, e[i]);
    end
  endtask
  // link clock at 80 ns; data pulled for two half periods, then released
  task t_bus;
    logic lvl;
    lvl = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      scl_in       <= i[0];
      sda_pull_low <= ~i[1];
      repeat (3) @(posedge core_clk);
      #1 chk({scl_sync, sda_oe, sda_in, sda_sync}, {i[0], ~i[1], i[1], lvl});
      lvl = i[1];
    end
  endtask
  // one conversion; hi is the high time, r the result
  task t_conv(input int hi, input logic f, en, input logic [11:0] r, input logic a, inv);
    @(posedge core_clk);
    pin_function <= f;
    alert_enable <= en;
    host.pulse(hi);
    repeat (5) @(posedge core_clk);
    #1 chk(track_hold, 1);
    chk(alert_busy_out | !f, 1);
    chk(conv_invalid, inv);
    @(posedge core_clk);
    conv_result <= r;
    conv_done   <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk({track_hold, converter_awake, result_out}, {2'h0, r});
    chk(alert_busy_out, a);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    t_idle;
    t_addr;
    t_bus;
    t_conv(10, 0, 1, 12'h900, 1, 0);
    t_conv(10, 0, 1, 12'h800, 0, 0);
    t_conv(10, 0, 1, 12'h0FF, 1, 0);
    t_conv(10, 0, 1, 12'h100, 0, 0);
    t_conv(2, 1, 1, 12'h900, 0, 1);
    t_conv(10, 0, 0, 12'h900, 0, 0);
    t_conv(4, 0, 1, 12'h800, 0, 0);
    t_conv(3, 0, 1, 12'h100, 0, 1);
    report_and_stop;
  end
  // hang guard, far beyond the expected few hundred cycles
  initial begin
    #100000;
    fail_count++;
    report_and_stop;
  end
endmodule
